// ---- hdl/icc_pkg.sv ----
// constants, register map and types for the two-wire controller
// clear-on-read and enable control block
// assumes one controller clock; engine events arrive on that clock
// Summary of operation
// - abort clear read clears flag and cause
// - abort clear read releases transmit FIFO hold
// - cause bit 9 survives the clearing read
// - receive-done clear read clears bit 7
// - activity clear only when bus idle
// - hardware clears activity when disabled and idle
// - activity clear read returns activity flag
// - stop clear read clears bit 9
// - start clear read clears bit 10
// - general call clear read clears bit 11
// - block bit holds off master transmission
// - block clear starts transmission on data
// - abort: stop, flush, flag, self clear
// - abort set only when enabled, cleared only by hardware
// - disable flushes both FIFOs after idle
// - enable changes act after two cycles
package icc_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_ABORT_CLR = 32'h5002_0354;
    localparam logic [ADDR_W-1:0] ADDR_RXDONE_CLR = 32'h5002_0358;
    localparam logic [ADDR_W-1:0] ADDR_ACT_CLR = 32'h5002_035c;
    localparam logic [ADDR_W-1:0] ADDR_STOP_CLR = 32'h5002_0360;
    localparam logic [ADDR_W-1:0] ADDR_START_CLR = 32'h5002_0364;
    localparam logic [ADDR_W-1:0] ADDR_GCALL_CLR = 32'h5002_0368;
    localparam logic [ADDR_W-1:0] ADDR_ENABLE = 32'h5002_036c;
    localparam logic [ADDR_W-1:0] ADDR_RAW_STAT = 32'h5002_03a0;
    localparam logic [ADDR_W-1:0] ADDR_CAUSE = 32'h5002_03a4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 32'h5002_03a8;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 32'h5002_03ac;
    localparam logic [ADDR_W-1:0] ADDR_STRIDE = 32'h0000_0004;

    // event flags, in raw status order starting at bit 6
    localparam int NUM_FLAGS = 6;
    localparam int FL_ABORT = 0;
    localparam int FL_RXDONE = 1;
    localparam int FL_ACT = 2;
    localparam int FL_STOP = 3;
    localparam int FL_START = 4;
    localparam int FL_GCALL = 5;
    localparam int RAW_FIRST_BIT = 6;

    // enable register fields
    localparam int ENA_EN_BIT = 0;
    localparam int ENA_ABORT_BIT = 1;
    localparam int ENA_BLOCK_BIT = 2;

    // abort cause bit that a clearing read leaves alone
    localparam int CAUSE_KEEP_BIT = 9;

    // block interrupt status and mask fields
    localparam int IRQ_W = 2;
    localparam int IRQ_ABORT_DONE = 0;
    localparam int IRQ_DISABLED = 1;

    // enable latency in controller clocks
    localparam int EN_LATENCY = 2;

    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        ICC_AB_IDLE = 2'b00,
        ICC_AB_REQ = 2'b01,
        ICC_AB_DONE = 2'b11
    } icc_abort_st_t;

endpackage

// ---- hdl/icc_core_if.sv ----
// signals between the control top and its flag bank and enable pipe
// assumes all three sit on the same controller clock
`timescale 1ns/1ps
`default_nettype none
interface icc_core_if;
    import icc_pkg::*;

    logic [NUM_FLAGS-1:0] hw_set;
    logic [NUM_FLAGS-1:0] hw_clr;
    logic [NUM_FLAGS-1:0] sw_clr;
    logic [NUM_FLAGS-1:0] flags;
    logic en_req;
    logic en_eff;

    modport bank (input hw_set, input hw_clr, input sw_clr, output flags);
    modport pipe (input en_req, output en_eff);
    modport top (output hw_set, output hw_clr, output sw_clr, output en_req,
                 input flags, input en_eff);
endinterface
`default_nettype wire

// ---- hdl/icc_flag_bank.sv ----
// sticky event flags with hardware set, hardware clear and read clear
// assumes set, clear and read strobes all come from the controller clock
`timescale 1ns/1ps
`default_nettype none
module icc_flag_bank
    import icc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // flag controls and values
    icc_core_if.bank fb
);
    import icc_pkg::*;

    typedef struct packed {
        logic [NUM_FLAGS-1:0] flag;
    } icc_bank_state_t;

    icc_bank_state_t st;
    icc_bank_state_t next_st;

    // next flag values, a set in the clearing cycle keeps the flag
    always_comb begin
        next_st = st;
        next_st.flag = (st.flag & ~(fb.sw_clr | fb.hw_clr)) | fb.hw_set;
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fb.flags = st.flag;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // one check per flag: a set always shows the next cycle
    for (genvar gi = 0; gi < NUM_FLAGS; gi++) begin : g_chk
        chk_set_wins_clear: assert property (
            fb.hw_set[gi] |=> fb.flags[gi])
            else $error("flag lost its set during a clear");
    end
endmodule
`default_nettype wire

// ---- hdl/icc_en_pipe.sv ----
// delays the software enable bit before the controller acts on it
// assumes the enable request comes from a register on the same clock
`timescale 1ns/1ps
`default_nettype none
module icc_en_pipe
    import icc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // enable request and effective enable
    icc_core_if.pipe ep
);
    import icc_pkg::*;

    typedef struct packed {
        logic [EN_LATENCY-1:0] stage;
    } icc_pipe_state_t;

    icc_pipe_state_t st;
    icc_pipe_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.stage = {st.stage[EN_LATENCY-2:0], ep.en_req};
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ep.en_eff = st.stage[EN_LATENCY-1];

    chk_en_two_cycles: assert property (
        @(posedge clk) disable iff (!rst_n)
        ep.en_eff == $past(ep.en_req, EN_LATENCY))
        else $error("enable did not take effect after two cycles");
endmodule
`default_nettype wire

// ---- hdl/icc_ctrl_top.sv ----
// clear-on-read event flags, enable register and abort control
// of a two-wire serial controller, with a plain register port
// assumes the protocol engine and FIFOs share clk and drive
// their event and status inputs from flip-flops
`timescale 1ns/1ps
`default_nettype none
module icc_ctrl_top
    import icc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [icc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [icc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [icc_pkg::DATA_W-1:0] reg_rdata,
    // protocol engine events
    input wire logic eng_tx_abort,
    input wire logic [icc_pkg::DATA_W-1:0] eng_abort_cause,
    input wire logic eng_rx_done,
    input wire logic eng_active,
    input wire logic eng_stop_seen,
    input wire logic eng_start_seen,
    input wire logic eng_general_call_flag,
    input wire logic eng_abort_done,
    // transmit FIFO status
    input wire logic tx_fifo_nonempty,
    // engine and FIFO controls
    output logic abort_req,
    output logic tx_start_ok,
    output logic tx_fifo_flush,
    output logic rx_fifo_flush,
    output logic ctrl_enabled,
    // interrupt
    output logic irq
);
    import icc_pkg::*;

    // one-hot select of the clear register at an address
    function automatic logic [NUM_FLAGS-1:0] clr_select(input logic [ADDR_W-1:0] a);
        logic [NUM_FLAGS-1:0] sel;
        sel = '0;
        for (int i = 0; i < NUM_FLAGS; i++) begin
            sel[i] = (a == ADDR_W'(ADDR_ABORT_CLR + ADDR_STRIDE * ADDR_W'(i)));
        end
        return sel;
    endfunction

    typedef struct packed {
        logic en;
        logic abort;
        logic block;
        icc_abort_st_t ab;
        logic tx_hold;
        logic [DATA_W-1:0] cause;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic en_eff_q;
        logic [DATA_W-1:0] rdata;
    } icc_top_state_t;

    icc_top_state_t st;
    icc_top_state_t next_st;

    icc_core_if core ();

    logic [NUM_FLAGS-1:0] rd_sel;
    logic [DATA_W-1:0] raw_stat;
    logic [DATA_W-1:0] cause_keep;
    logic [IRQ_W-1:0] irq_events;
    logic wr_enable;
    logic wr_irq_stat;
    logic wr_irq_mask;
    logic abort_event;

    // flag bank and enable pipe
    icc_flag_bank u_bank (
        .clk(clk),
        .rst_n(rst_n),
        .fb(core.bank)
    );

    icc_en_pipe u_pipe (
        .clk(clk),
        .rst_n(rst_n),
        .ep(core.pipe)
    );

    // address decode; clear registers have no write decode at all
    // clear register writes ignored
    always_comb begin
        rd_sel = reg_rd ? clr_select(reg_addr) : '0;
        wr_enable = reg_wr && (reg_addr == ADDR_ENABLE);
        wr_irq_stat = reg_wr && (reg_addr == ADDR_IRQ_STAT);
        wr_irq_mask = reg_wr && (reg_addr == ADDR_IRQ_MASK);
    end

    // raw event status view, flags sit at bits 6 to 11
    always_comb begin
        raw_stat = '0;
        raw_stat[RAW_FIRST_BIT +: NUM_FLAGS] = core.flags;
    end

    // abort completion raises the abort flag
    assign abort_event = (st.ab == ICC_AB_DONE);

    // flag set and clear sources
    always_comb begin
        core.hw_set = '0;
        core.hw_set[FL_ABORT] = eng_tx_abort || abort_event;
        core.hw_set[FL_RXDONE] = eng_rx_done;
        // activity re-sets while the bus is busy
        core.hw_set[FL_ACT] = eng_active;
        core.hw_set[FL_STOP] = eng_stop_seen;
        core.hw_set[FL_START] = eng_start_seen;
        core.hw_set[FL_GCALL] = eng_general_call_flag;
        core.hw_clr = '0;
        core.hw_clr[FL_ACT] = !core.en_eff && !eng_active;
        core.sw_clr = rd_sel;
    end

    assign core.en_req = st.en;

    // cause bits that survive a clearing read
    always_comb begin
        cause_keep = '0;
        cause_keep[CAUSE_KEEP_BIT] = 1'b1;
    end

    // block interrupt events
    always_comb begin
        irq_events = '0;
        irq_events[IRQ_ABORT_DONE] = abort_event;
        irq_events[IRQ_DISABLED] = st.en_eff_q && !core.en_eff;
    end

    // next state of the control registers
    always_comb begin
        next_st = st;
        next_st.en_eff_q = core.en_eff;

        if (wr_enable) begin
            next_st.en = reg_wdata[ENA_EN_BIT];
            next_st.block = reg_wdata[ENA_BLOCK_BIT];
        end

        // abort may only be set, and only when enabled
        if (wr_enable && reg_wdata[ENA_ABORT_BIT] && st.en) begin
            next_st.abort = 1'b1;
        end

        unique case (st.ab)
            ICC_AB_IDLE: begin
                if (st.abort) begin
                    next_st.ab = ICC_AB_REQ;
                end
            end
            ICC_AB_REQ: begin
                if (eng_abort_done) begin
                    next_st.ab = ICC_AB_DONE;
                end
            end
            ICC_AB_DONE: begin
                next_st.ab = ICC_AB_IDLE;
                next_st.abort = 1'b0;
            end
            default: begin
                next_st.ab = ICC_AB_IDLE;
            end
        endcase

        // cause clears on read except the kept bit
        if (rd_sel[FL_ABORT]) begin
            next_st.cause = st.cause & cause_keep;
        end
        // new cause bits win over the clear
        if (eng_tx_abort) begin
            next_st.cause = next_st.cause | eng_abort_cause;
        end

        // clear read releases the transmit hold
        if (rd_sel[FL_ABORT]) begin
            next_st.tx_hold = 1'b0;
        end
        // abort flushes and holds the transmit FIFO
        if (eng_tx_abort || abort_event) begin
            next_st.tx_hold = 1'b1;
        end

        // interrupt status, write one to clear, events win
        if (wr_irq_stat) begin
            next_st.irq_stat = st.irq_stat & ~reg_wdata[IRQ_W-1:0];
        end
        next_st.irq_stat = next_st.irq_stat | irq_events;
        if (wr_irq_mask) begin
            next_st.irq_mask = reg_wdata[IRQ_W-1:0];
        end

        // read data, valid only the cycle after the read strobe
        next_st.rdata = RST_WORD;
        if (reg_rd) begin
            if (|rd_sel) begin
                next_st.rdata[0] = |(rd_sel & core.flags);
            end else if (reg_addr == ADDR_ENABLE) begin
                next_st.rdata[ENA_EN_BIT] = st.en;
                next_st.rdata[ENA_ABORT_BIT] = st.abort;
                next_st.rdata[ENA_BLOCK_BIT] = st.block;
            end else if (reg_addr == ADDR_RAW_STAT) begin
                next_st.rdata = raw_stat;
            end else if (reg_addr == ADDR_CAUSE) begin
                next_st.rdata = st.cause;
            end else if (reg_addr == ADDR_IRQ_STAT) begin
                next_st.rdata[IRQ_W-1:0] = st.irq_stat;
            end else if (reg_addr == ADDR_IRQ_MASK) begin
                next_st.rdata[IRQ_W-1:0] = st.irq_mask;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{ab: ICC_AB_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign reg_rdata = st.rdata;
    assign abort_req = (st.ab == ICC_AB_REQ);
    assign ctrl_enabled = core.en_eff;
    assign tx_start_ok = core.en_eff && !st.block && tx_fifo_nonempty && !st.tx_hold;
    // flush both FIFOs once disabled and idle
    assign rx_fifo_flush = !core.en_eff && !eng_active;
    assign tx_fifo_flush = rx_fifo_flush || st.tx_hold;
    assign irq = |(st.irq_stat & st.irq_mask);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_abort_flag_clear: assert property (
        rd_sel[FL_ABORT] && !core.hw_set[FL_ABORT] |=> !core.flags[FL_ABORT])
        else $error("abort flag not cleared by its read");

    chk_cause_keep_bit: assert property (
        rd_sel[FL_ABORT] && !eng_tx_abort
        |=> (st.cause & ~cause_keep) == RST_WORD
            && st.cause[CAUSE_KEEP_BIT] == $past(st.cause[CAUSE_KEEP_BIT]))
        else $error("abort cause clear wrong");

    chk_tx_release: assert property (
        rd_sel[FL_ABORT] && !eng_tx_abort && !abort_event |=> !tx_fifo_flush || rx_fifo_flush)
        else $error("transmit FIFO not released");

    chk_rxdone_clear: assert property (
        rd_sel[FL_RXDONE] && !eng_rx_done |=> !raw_stat[RAW_FIRST_BIT + FL_RXDONE])
        else $error("receive done flag not cleared");

    chk_act_stays: assert property (
        rd_sel[FL_ACT] && eng_active |=> core.flags[FL_ACT])
        else $error("activity flag cleared while busy");

    chk_act_hw_clear: assert property (
        !core.en_eff && !eng_active |=> !core.flags[FL_ACT])
        else $error("activity flag not cleared when idle and disabled");

    chk_act_readback: assert property (
        rd_sel[FL_ACT] |=> reg_rdata[0] == $past(core.flags[FL_ACT]))
        else $error("activity read value wrong");

    chk_stop_clear: assert property (
        rd_sel[FL_STOP] && !eng_stop_seen |=> !core.flags[FL_STOP])
        else $error("stop flag not cleared");

    chk_gcall_clear: assert property (
        rd_sel[FL_GCALL] && !eng_general_call_flag |=> !core.flags[FL_GCALL])
        else $error("general call flag not cleared");

    chk_block_holds: assert property (
        st.block |-> !tx_start_ok)
        else $error("transmission started while blocked");

    chk_abort_ignored: assert property (
        wr_enable && !st.en && !st.abort |=> !st.abort)
        else $error("abort set while disabled");

    chk_abort_sequence: assert property (
        abort_req && eng_abort_done
        |=> core.hw_set[FL_ABORT] ##1 !st.abort && tx_fifo_flush && core.flags[FL_ABORT])
        else $error("abort completion sequence wrong");

    chk_flush_disabled: assert property (
        !core.en_eff && !eng_active |-> rx_fifo_flush && tx_fifo_flush)
        else $error("FIFOs not flushed while disabled");

    chk_start_clear: assert property (
        rd_sel[FL_START] && !eng_start_seen |=> !core.flags[FL_START])
        else $error("start flag not cleared");

    chk_act_clear_idle: assert property (
        rd_sel[FL_ACT] && !eng_active |=> !core.flags[FL_ACT])
        else $error("activity flag kept although bus idle");

    chk_clr_write_nop: assert property (
        reg_wr && !reg_rd && (|clr_select(reg_addr))
            && core.hw_set == '0 && core.hw_clr == '0
        |=> $stable(core.flags) && $stable(st.cause) && $stable(st.tx_hold))
        else $error("write to a clear register changed state");

    chk_enable_fields: assert property (
        wr_enable |=> st.en == $past(reg_wdata[ENA_EN_BIT])
            && st.block == $past(reg_wdata[ENA_BLOCK_BIT]))
        else $error("enable register fields not written");

    chk_abort_accept: assert property (
        wr_enable && reg_wdata[ENA_ABORT_BIT] && st.en && st.ab != ICC_AB_DONE |=> st.abort)
        else $error("abort write refused while enabled");

    chk_abort_sticky: assert property (
        st.abort && st.ab != ICC_AB_DONE |=> st.abort)
        else $error("abort bit cleared before the abort finished");

    chk_abort_request: assert property (
        st.ab == ICC_AB_IDLE && st.abort |=> abort_req)
        else $error("abort request not raised");

    chk_abort_hold: assert property (
        eng_tx_abort |=> core.flags[FL_ABORT] && tx_fifo_flush)
        else $error("engine abort did not set flag and hold");

    chk_cause_new_bits: assert property (
        eng_tx_abort |=> (st.cause & $past(eng_abort_cause)) == $past(eng_abort_cause))
        else $error("new abort cause bits lost");

    chk_start_allowed: assert property (
        ctrl_enabled && !st.block && tx_fifo_nonempty && !st.tx_hold |-> tx_start_ok)
        else $error("transmission held although not blocked");
endmodule
`default_nettype wire

// ---- test/icc_eng_model.sv ----
// engine stand-in that answers an abort request after a set delay
// assumes the abort request is a level held until the done pulse
`timescale 1ns/1ps
`default_nettype none
module icc_eng_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // abort handshake
    input wire logic abort_req,
    input wire logic [7:0] delay,
    output logic abort_done
);
    logic [7:0] cnt;

    // count request cycles, then pulse done once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            abort_done <= 1'b0;
        end else if (abort_req && !abort_done) begin
            abort_done <= (cnt == delay);
            cnt <= (cnt == delay) ? 8'h00 : cnt + 8'h01;
        end else begin
            cnt <= 8'h00;
            abort_done <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking bench for the clear-on-read and enable control block
// assumes one 200 MHz clock and the engine stand-in for abort requests
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import icc_pkg::*;
    logic clk, rst_n, reg_wr, reg_rd, txne, abort_req, tx_start_ok;
    logic txf, rxf, ctrl_enabled, irq, abort_done;
    logic [31:0] reg_addr, reg_wdata, reg_rdata, cause, d;
    logic [5:0] ev;
    logic [7:0] dly;
    int failures, compares, seed, i, n;

    icc_ctrl_top i_icc_ctrl_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .eng_tx_abort(ev[FL_ABORT]), .eng_abort_cause(cause), .eng_rx_done(ev[FL_RXDONE]),
        .eng_active(ev[FL_ACT]), .eng_stop_seen(ev[FL_STOP]), .eng_start_seen(ev[FL_START]),
        .eng_general_call_flag(ev[FL_GCALL]), .eng_abort_done(abort_done), .tx_fifo_nonempty(txne),
        .abort_req(abort_req), .tx_start_ok(tx_start_ok), .tx_fifo_flush(txf),
        .rx_fifo_flush(rxf), .ctrl_enabled(ctrl_enabled), .irq(irq));
    icc_eng_model i_icc_eng_model (.clk(clk), .rst_n(rst_n), .abort_req(abort_req),
        .delay(dly), .abort_done(abort_done));

    // compare a register word
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // compare a single output
    task automatic chk_b(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic close_out;
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // one-cycle register write
    task automatic wr(input logic [31:0] a, input logic [31:0] w);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // one-cycle read, optionally with engine events in the same cycle
    task automatic rd(input logic [31:0] a, input logic [5:0] also, output logic [31:0] q);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        ev <= ev | also;
        @(posedge clk);
        reg_rd <= 1'b0;
        ev <= ev & ~also;
        #1;
        q = reg_rdata;
    endtask
    // one engine event pulse
    task automatic pulse(input int f);
        @(posedge clk);
        ev <= ev | (6'h01 << f);
        @(posedge clk);
        ev <= ev & ~(6'h01 << f);
    endtask
    // let one more edge land
    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    // expected addresses and values
    function automatic logic [31:0] clr_addr(input int f);
        return ADDR_ABORT_CLR + ADDR_STRIDE * f;
    endfunction
    function automatic logic [31:0] raw_mask(input int f);
        return 32'h1 << (RAW_FIRST_BIT + f);
    endfunction
    function automatic logic [31:0] cause_left(input logic [31:0] c);
        return c & (32'h1 << CAUSE_KEEP_BIT);
    endfunction

    // clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        close_out();
    end
    // main sequence
    initial begin
        seed = 95;
        failures = 0;
        compares = 0;
        rst_n = 1'b0;
        reg_addr = 32'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ev = 6'h00;
        cause = 32'h0;
        txne = 1'b0;
        dly = 8'h01;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // reset values of clear and enable registers, then an unmapped word
        for (i = 0; i <= NUM_FLAGS; i++) begin
            rd(clr_addr(i), 6'h00, d);
            chk_w(d, RST_WORD);
        end
        n = $unsigned($random(seed)) % 4;
        rd(32'h5002_0370 + 32'(n * 4), 6'h00, d);
        chk_w(d, 32'h0);
        chk_b(abort_req, 1'b0);
        // enable latency
        wr(ADDR_ENABLE, 32'h1);
        settle();
        chk_b(ctrl_enabled, 1'b0);
        settle();
        chk_b(ctrl_enabled, 1'b1);
        chk_b(rxf, 1'b0);
        // each flag: set, ignored write, clearing read
        @(posedge clk);
        cause <= $random(seed) | 32'h200;
        for (i = 0; i < NUM_FLAGS; i++) begin
            pulse(i);
            wr(clr_addr(i), $random(seed));
            rd(ADDR_RAW_STAT, 6'h00, d);
            chk_w(d & raw_mask(i), raw_mask(i));
            if (i == FL_ABORT) begin
                chk_b(txf, 1'b1);
                rd(ADDR_CAUSE, 6'h00, d);
                chk_w(d, cause);
            end
            rd(clr_addr(i), 6'h00, d);
            chk_w(d, 32'h1);
            rd(ADDR_RAW_STAT, 6'h00, d);
            chk_w(d & raw_mask(i), 32'h0);
            if (i == FL_ABORT) begin
                chk_b(txf, 1'b0);
                rd(ADDR_CAUSE, 6'h00, d);
                chk_w(d, cause_left(cause));
            end
        end
        // activity clear refused while the bus is busy
        @(posedge clk);
        ev[FL_ACT] <= 1'b1;
        rd(ADDR_ACT_CLR, 6'h00, d);
        chk_w(d, 32'h1);
        rd(ADDR_RAW_STAT, 6'h00, d);
        chk_w(d & raw_mask(FL_ACT), raw_mask(FL_ACT));
        @(posedge clk);
        ev[FL_ACT] <= 1'b0;
        // event in the same cycle as its clearing read
        rd(ADDR_STOP_CLR, 6'h01 << FL_STOP, d);
        rd(ADDR_RAW_STAT, 6'h00, d);
        chk_w(d & raw_mask(FL_STOP), raw_mask(FL_STOP));
        // transmit block bit, reserved bits written but read back as zero
        @(posedge clk);
        txne <= 1'b1;
        wr(ADDR_ENABLE, 32'hffff_fffd);
        settle();
        chk_b(tx_start_ok, 1'b0);
        rd(ADDR_ENABLE, 6'h00, d);
        chk_w(d, 32'h5);
        wr(ADDR_ENABLE, 32'h1);
        settle();
        chk_b(tx_start_ok, 1'b1);
        // disable with activity pending, abort write refused
        pulse(FL_ACT);
        wr(ADDR_ENABLE, 32'h0);
        wr(ADDR_ENABLE, 32'h2);
        rd(ADDR_ENABLE, 6'h00, d);
        chk_w(d, 32'h0);
        chk_b(rxf, 1'b1);
        chk_b(txf, 1'b1);
        for (n = 0; n < 8; n++) begin
            rd(ADDR_RAW_STAT, 6'h00, d);
            if ((d & raw_mask(FL_ACT)) == 32'h0) break;
        end
        // bound used up: count it and report
        if (n == 8) begin
            failures++;
            close_out();
        end
        chk_w(d & raw_mask(FL_ACT), 32'h0);
        // interrupt: raised, masked, cleared
        rd(ADDR_IRQ_STAT, 6'h00, d);
        chk_w(d, 32'h2);
        chk_b(irq, 1'b0);
        wr(ADDR_IRQ_MASK, 32'h3);
        settle();
        chk_b(irq, 1'b1);
        wr(ADDR_IRQ_STAT, 32'h2);
        settle();
        chk_b(irq, 1'b0);
        // abort with a slow engine; software cannot clear the bit
        wr(ADDR_ENABLE, 32'h1);
        dly <= 8'h08 + 8'($unsigned($random(seed)) % 8);
        wr(ADDR_ENABLE, 32'h3);
        wr(ADDR_ENABLE, 32'h1);
        rd(ADDR_ENABLE, 6'h00, d);
        chk_w(d, 32'h3);
        chk_b(abort_req, 1'b1);
        for (n = 0; n < 40 && abort_req; n++) begin
            @(posedge clk);
        end
        // engine never finished: count it and report
        if (n == 40) begin
            failures++;
            close_out();
        end
        settle();
        settle();
        chk_b(abort_req, 1'b0);
        chk_b(txf, 1'b1);
        rd(ADDR_ENABLE, 6'h00, d);
        chk_w(d, 32'h1);
        rd(ADDR_RAW_STAT, 6'h00, d);
        chk_w(d & raw_mask(FL_ABORT), raw_mask(FL_ABORT));
        rd(ADDR_IRQ_STAT, 6'h00, d);
        chk_w(d, 32'h1);
        settle();
        chk_b(irq, 1'b1);
        rd(ADDR_ABORT_CLR, 6'h00, d);
        chk_w(d, 32'h1);
        settle();
        chk_b(txf, 1'b0);
        close_out();
    end
endmodule
`default_nettype wire
